// File: design/dsar_pkg.sv
// Shared constants and carrier types for the dual sample converter readout
package dsar_pkg;

    // Result width of each converter
    localparam int unsigned DATA_W = 14;
    // Full conversion time in nanoseconds
    localparam int unsigned CONV_TIME_NS = 5200;
    // Clock period in nanoseconds
    localparam int unsigned CLK_PERIOD_NS = 4;
    // Conversion cycles, longest time so rounded down
    localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    // Worst-case cycles from the start pin to edge detection, spent from the conversion budget
    localparam int unsigned SYNC_CYCLES = 5;
    // Wake-up time before a conversion may begin, in nanoseconds
    localparam int unsigned WAKE_TIME_NS = 40;
    // Wake-up cycles, least time so rounded up
    localparam int unsigned WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Reset value of the data bus
    localparam logic [13:0] DATA_RST = 14'h0000;

    // Result pair as produced by the two converters
    typedef struct packed {
        logic [DATA_W-1:0] first;
        logic [DATA_W-1:0] second;
    } dsar_pair_t;

    // Host read strobes after synchronisation
    typedef struct packed {
        logic cs;
        logic rd;
    } dsar_rd_t;

endpackage : dsar_pkg

// File: design/dsar_sync.sv
// Three-stage pin synchroniser with second/third agreement filter
`timescale 1ns/1ps

module dsar_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    // Synchroniser stages; stage one is read only by stage two
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    // Filtered level
    logic [WIDTH-1:0] lvl_r;
    logic [WIDTH-1:0] lvl_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Accept a change once the second and third stages agree
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
        end
    end

    // Register the stages and the filtered level
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
            lvl_r <= '1;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign level_out = lvl_r;

endmodule // dsar_sync

// File: design/dsar_readout.sv
// Conversion control and parallel readout for a dual simultaneous-sampling converter
`timescale 1ns/1ps

// Functional notes
// - Start holds both stages, converts both together
// - Both results ready within 5.2 us
// - Busy ends when both results readable
// - First read first input, second read second
// - Fourteen-bit bus, read by select and strobe
// - Power down after conversion, wake before next
module dsar_readout #(
    parameter int unsigned CONV_CYCLES = dsar_pkg::CONV_CYCLES,
    parameter int unsigned WAKE_CYCLES = dsar_pkg::WAKE_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic conversion_start_n,
    input wire logic pair_select,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic [13:0] pair_a_first_input,
    input wire logic [13:0] pair_a_second_input,
    input wire logic [13:0] pair_b_first_input,
    input wire logic [13:0] pair_b_second_input,
    output logic busy,
    output logic track_hold,
    output logic power_down,
    output logic [13:0] data_out,
    output logic data_oe,
    output logic [1:0] conv_start_pulse
);

    // Elaboration checks on timing counts
    if (CONV_CYCLES < WAKE_CYCLES + dsar_pkg::SYNC_CYCLES + 2 || CONV_CYCLES > 65535 || WAKE_CYCLES < 1)
    begin : g_bad_conv
        $error("CONV_CYCLES out of range");
    end

    // Controller states
    typedef enum logic [1:0] {
        ST_SLEEP = 2'b00,
        ST_WAKE  = 2'b01,
        ST_CONV  = 2'b10,
        ST_DONE  = 2'b11
    } dsar_state_t;

    // Synchronised pins: start, pair select, chip select, read
    logic [3:0] pins_sync;
    logic start_lvl;
    logic pair_lvl;
    dsar_pkg::dsar_rd_t rd_lvl;

    // Control state
    dsar_state_t state_r;
    dsar_state_t state_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic start_prev_r;
    logic start_prev_nxt;
    logic pair_r;
    logic pair_nxt;
    logic busy_r;
    logic busy_nxt;
    logic hold_r;
    logic hold_nxt;
    logic pd_r;
    logic pd_nxt;
    logic [1:0] cstart_r;
    logic [1:0] cstart_nxt;
    // Result latches and read pointer
    dsar_pkg::dsar_pair_t res_r;
    dsar_pkg::dsar_pair_t res_nxt;
    logic rd_second_r;
    logic rd_second_nxt;
    logic rd_prev_r;
    logic rd_prev_nxt;
    logic [13:0] dout_r;
    logic [13:0] dout_nxt;
    logic oe_r;
    logic oe_nxt;
    // Derived events
    logic start_fall;
    logic rd_active;
    logic rd_end;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    dsar_sync #(
        .WIDTH(4)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .pin_in({conversion_start_n, pair_select, chip_select_n, read_n}),
        .level_out(pins_sync)
    );

    assign start_lvl = pins_sync[3];
    assign pair_lvl = pins_sync[2];
    assign rd_lvl.cs = ~pins_sync[1];
    assign rd_lvl.rd = ~pins_sync[0];
    assign start_fall = start_prev_r & ~start_lvl;
    assign rd_active = rd_lvl.cs & rd_lvl.rd;
    assign rd_end = rd_prev_r & ~rd_active;

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        start_prev_nxt = start_lvl;
        pair_nxt = pair_r;
        busy_nxt = busy_r;
        hold_nxt = hold_r;
        pd_nxt = pd_r;
        cstart_nxt = 2'b00;
        res_nxt = res_r;
        unique case (state_r)
            ST_SLEEP, ST_DONE:
            begin
                // Start edge: wake, then convert
                if (start_fall)
                begin
                    hold_nxt = 1'b1;
                    busy_nxt = 1'b1;
                    pair_nxt = pair_lvl;
                    pd_nxt = 1'b0;
                    cnt_nxt = 16'(WAKE_CYCLES);
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE:
            begin
                // Wake time elapsed before conversion starts
                if (cnt_r <= 16'h0001)
                begin
                    cstart_nxt = 2'b11;
                    // Pin synchroniser delay comes off the budget so results meet the limit from the pin
                    cnt_nxt = 16'(CONV_CYCLES - WAKE_CYCLES - dsar_pkg::SYNC_CYCLES - 1);
                    state_nxt = ST_CONV;
                end
                else
                begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            ST_CONV:
            begin
                if (cnt_r <= 16'h0001)
                begin
                    res_nxt.first = pair_r ? pair_b_first_input : pair_a_first_input;
                    res_nxt.second = pair_r ? pair_b_second_input : pair_a_second_input;
                    busy_nxt = 1'b0;
                    hold_nxt = 1'b0;
                    pd_nxt = 1'b1;
                    state_nxt = ST_DONE;
                end
                else
                begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
        endcase
    end

    // Conversion sequencer registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_r <= ST_SLEEP;
            cnt_r <= 16'h0000;
            start_prev_r <= 1'b1;
            pair_r <= 1'b0;
            busy_r <= 1'b0;
            hold_r <= 1'b0;
            pd_r <= 1'b1;
            cstart_r <= 2'b00;
            res_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            start_prev_r <= start_prev_nxt;
            pair_r <= pair_nxt;
            busy_r <= busy_nxt;
            hold_r <= hold_nxt;
            pd_r <= pd_nxt;
            cstart_r <= cstart_nxt;
            res_r <= res_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port next state
    always_comb
    begin
        rd_prev_nxt = rd_active;
        rd_second_nxt = rd_second_r;
        if (start_fall)
        begin
            rd_second_nxt = 1'b0;
        end
        // Read completion toggles between the first and second result
        else if (rd_end)
        begin
            rd_second_nxt = ~rd_second_r;
        end
        oe_nxt = rd_active;
        dout_nxt = rd_active ? (rd_second_r ? res_r.second : res_r.first) : dout_r;
    end

    // Read port registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rd_prev_r <= 1'b0;
            rd_second_r <= 1'b0;
            oe_r <= 1'b0;
            dout_r <= dsar_pkg::DATA_RST;
        end
        else
        begin
            rd_prev_r <= rd_prev_nxt;
            rd_second_r <= rd_second_nxt;
            oe_r <= oe_nxt;
            dout_r <= dout_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign busy = busy_r;
    assign track_hold = hold_r;
    assign power_down = pd_r;
    assign data_out = dout_r;
    assign data_oe = oe_r;
    assign conv_start_pulse = cstart_r;

endmodule // dsar_readout

// File: dv/dsar_readout_assertions.sv
// Port checks for the dual sample readout
`timescale 1ns/1ps

module dsar_readout_chk #(
    parameter int unsigned CONV_CYCLES = 20,
    parameter int unsigned WAKE_CYCLES = 2
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic busy,
    input wire logic track_hold,
    input wire logic power_down,
    input wire logic [13:0] data_out,
    input wire logic data_oe,
    input wire logic [1:0] conv_start_pulse
);
    // Delay bounds
    localparam int C = CONV_CYCLES;
    localparam int W = WAKE_CYCLES;
    // Longest busy count that still meets the conversion limit from the pin
    localparam int BUSY_MAX = C - dsar_pkg::SYNC_CYCLES - 1;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Cycles busy has been seen high
    logic [15:0] busy_cnt_r;
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            busy_cnt_r <= 16'h0000;
        end
        else
        begin
            busy_cnt_r <= busy ? busy_cnt_r + 16'h0001 : 16'h0000;
        end
    end
    ////////////////////////////////////////////////////////////////
    hold_busy_a: assert property (track_hold == busy)
        else $error("hold and busy disagree");
    both_start_a: assert property (conv_start_pulse != 2'h1 && conv_start_pulse != 2'h2)
        else $error("converters started apart");
    wake_time_a: assert property ($rose(busy) |-> ##W conv_start_pulse == 2'h3)
        else $error("start pulse not after wake time");
    conv_len_a: assert property (busy |-> busy_cnt_r < 16'(BUSY_MAX))
        else $error("conversion length wrong");
    sleep_after_a: assert property ($fell(busy) |-> power_down)
        else $error("no power down after conversion");
    awake_busy_a: assert property (busy |-> !power_down)
        else $error("powered down while busy");
    idle_bus_a: assert property ((chip_select_n || read_n)[*5] |=> !data_oe)
        else $error("bus driven without read");
    read_drive_a: assert property ((!chip_select_n && !read_n)[*5] |=> data_oe)
        else $error("bus not driven during read");
    data_hold_a: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
        else $error("data changed during read");
    reset_state_a: assert property ($past(rst) |-> !busy && power_down && !data_oe)
        else $error("wrong state after reset");
    ////////////////////////////////////////////////////////////////
    cover property ($fell(busy));
    cover property ($rose(data_oe));
    cover property (conv_start_pulse == 2'h3);
endmodule // dsar_readout_chk

bind dsar_readout dsar_readout_chk #(.CONV_CYCLES(CONV_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) chk_i (.*);

// File: dv/dsar_host.sv
// Host model that starts conversions and reads results
`timescale 1ns/1ps

module dsar_host (
    input wire logic mclk,
    input wire logic busy,
    input wire logic data_oe,
    input wire logic [13:0] data_out,
    output logic conversion_start_n,
    output logic pair_select,
    output logic chip_select_n,
    output logic read_n
);
    // Strobes idle high
    initial
    begin
        conversion_start_n = 1'b1;
        pair_select = 1'b0;
        chip_select_n = 1'b1;
        read_n = 1'b1;
    end
    task automatic convert(input logic sel, output int len);
        int i;
        len = 0;
        @(negedge mclk);
        pair_select = sel;
        conversion_start_n = 1'b0;
        // Length counted from the start pin, not from busy
        for (i = 0; i < 20 && busy !== 1'b1; i++)
        begin
            @(negedge mclk);
            len++;
        end
        // Select flipped once latched
        conversion_start_n = 1'b1;
        pair_select = ~sel;
        for (i = 0; i < 3000 && busy === 1'b1; i++)
        begin
            @(negedge mclk);
            len++;
        end
    endtask
    task automatic read(output logic [13:0] d);
        int i;
        @(negedge mclk);
        chip_select_n = 1'b0;
        read_n = 1'b0;
        for (i = 0; i < 12 && data_oe !== 1'b1; i++) @(negedge mclk);
        d = (data_oe === 1'b1) ? data_out : 'x;
        chip_select_n = 1'b1;
        read_n = 1'b1;
        for (i = 0; i < 12 && data_oe !== 1'b0; i++) @(negedge mclk);
    endtask
endmodule // dsar_host

// File: dv/test_dsar_readout.sv
// Self-checking bench for the dual sample readout
`timescale 1ns/1ps

module test_dsar_readout;
    localparam int unsigned CONVC = 20; // Shortened conversion
    localparam int unsigned WAKEC = 2; // Shortened wake-up
    logic mclk, rst, cs_n, rd_n, start_n, sel, busy, hold, pd, data_oe;
    logic [13:0] a1, a2, b1, b2, data_out;
    logic [1:0] pulse;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    dsar_readout #(.CONV_CYCLES(CONVC), .WAKE_CYCLES(WAKEC)) dsar_readout_i (.mclk(mclk), .rst(rst),
        .conversion_start_n(start_n), .pair_select(sel), .chip_select_n(cs_n), .read_n(rd_n),
        .pair_a_first_input(a1), .pair_a_second_input(a2), .pair_b_first_input(b1),
        .pair_b_second_input(b2), .busy(busy), .track_hold(hold), .power_down(pd),
        .data_out(data_out), .data_oe(data_oe), .conv_start_pulse(pulse));
    dsar_host dsar_host_i (.mclk(mclk), .busy(busy), .data_oe(data_oe), .data_out(data_out),
        .conversion_start_n(start_n), .pair_select(sel), .chip_select_n(cs_n), .read_n(rd_n));
    ////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Verdict and end of run
    task automatic results;
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////
    // One conversion, then three reads
    task automatic t_pair(input logic s, input logic [13:0] f, input logic [13:0] g);
        int len;
        logic [13:0] d;
        dsar_host_i.convert(s, len);
        chk("busy_len", 14'(CONVC - 1), 14'(len));
        chk("power_down", 14'h0001, 14'(pd));
        chk("track_hold", 14'h0000, 14'(hold));
        dsar_host_i.read(d);
        chk("first", f, d);
        dsar_host_i.read(d);
        chk("second", g, d);
        dsar_host_i.read(d);
        chk("third", f, d);
        chk("data_oe", 14'h0000, 14'(data_oe));
    endtask
    // New start after one read resets order
    task automatic t_restart;
        int len;
        logic [13:0] d;
        dsar_host_i.convert(1'b0, len);
        dsar_host_i.read(d);
        dsar_host_i.convert(1'b1, len);
        dsar_host_i.read(d);
        chk("restart_first", b1, d);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        a1 = 14'h1A2B;
        a2 = 14'h0C3D;
        b1 = 14'h2E4F;
        b2 = 14'h3561;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        repeat (6) @(negedge mclk);
        chk("reset_pd", 14'h0001, 14'(pd));
        chk("reset_busy", 14'h0000, 14'(busy));
        t_pair(1'b0, a1, a2);
        t_pair(1'b1, b1, b2);
        t_restart();
        results();
    end
endmodule // test_dsar_readout
